//--- design/gdsc_pkg.sv
// Purpose: Constants for the gate driver state control block
// Assumes: 125 MHz clock, 8 ns period
// Notes:   Operation
package gdsc_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [3:0] ADDR_CFG    = 4'h0;  // Control bits
    localparam logic [3:0] ADDR_STATUS = 4'h1;  // Latched fault flags
    localparam logic [3:0] ADDR_STATE  = 4'h2;  // Operating state
    localparam logic [3:0] ADDR_EVENT  = 4'h3;  // Filtered input levels
    // Control register field positions
    localparam int CFG_FILT_LO  = 0;   // Input filter select, 2 bits
    localparam int CFG_SOFTDIS  = 2;   // Cycle soft-off disable
    localparam logic [7:0] CFG_RESET = 8'h04;  // Soft-off disabled
    // Status register bit positions
    localparam int ST_HUV  = 0;
    localparam int ST_HOV  = 1;
    localparam int ST_DES  = 2;
    localparam int ST_TSD  = 3;
    localparam int ST_SNS  = 4;
    localparam int ST_IREG = 5;
    localparam int ST_NUV  = 6;
    localparam int ST_NOV  = 7;
    localparam int ST_LREG = 8;
    localparam int ST_PON  = 9;
    localparam int ST_ICOM = 10;
    localparam logic [10:0] GRP2_MASK = 11'h03f;
    localparam logic [10:0] GRP1_MASK = 11'h1ff;
    localparam logic [10:0] STATUS_RESET = 11'h000;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 8000;
    localparam int MIN_PULSE_NS  = 40;     // Minimum input pulse
    localparam int DEAD_NS       = 80;     // Push-pull deadtime
    localparam int SHORT_DEL_NS  = 2000;   // Phase short entry delay
    localparam int WDOG_US       = 100;    // Communication watchdog
    localparam int DEGL_A_NS     = 160;    // Filter select 01
    localparam int DEGL_B_NS     = 480;    // Filter select 10
    localparam int DEGL_C_NS     = 960;    // Filter select 11
    // Least times round up
    localparam int MIN_PULSE_CYC =
        (MIN_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEAD_CYC =
        (DEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SHORT_DEL_CYC =
        (SHORT_DEL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEGL_A_CYC =
        (DEGL_A_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEGL_B_CYC =
        (DEGL_B_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DEGL_C_CYC =
        (DEGL_C_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WDOG_CYC_DEF =
        (WDOG_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Operating states
    typedef enum logic [1:0] {
        GDSC_NORMAL,
        GDSC_SAFE,
        GDSC_SHORT
    } gdsc_state_t;
endpackage : gdsc_pkg

//--- design/gdsc_top.sv
// Purpose: Operating state machine, truth table, filters, deadtime
// Assumes: All inputs synchronous to clk; faults are levels
// Notes:   Soft-off pin is a tristate pin as output and enable
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module gdsc_top #(
    parameter int WDOG_CYC = gdsc_pkg::WDOG_CYC_DEF
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Pwm channel inputs
    input  wire logic        shutdown_n,
    input  wire logic        in_pos,
    input  wire logic        in_neg,
    input  wire logic        short_override,
    input  wire logic        default_mode,
    // Data channel activity, a pulse per received frame
    input  wire logic        lv_frame_ok,
    // Fault levels
    input  wire logic        high_supply_undervolt,
    input  wire logic        high_supply_overvolt,
    input  wire logic        desaturation_fault,
    input  wire logic        thermal_shutdown,
    input  wire logic        sense_overcurrent,
    input  wire logic        iso_register_error,
    input  wire logic        neg_supply_undervolt,
    input  wire logic        neg_supply_overvolt,
    input  wire logic        lv_register_error,
    // Pre-driver and soft-off pins
    output logic             predrive_p,
    output logic             predrive_n,
    output logic             soft_off_pin_o,
    output logic             soft_off_pin_oe_n,
    // Event pulse to the data channel
    output logic             diag_event
);
    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0]         cfg_ff;          // Control register
    logic [10:0]        status_ff;       // Latched flags
    logic [10:0]        fault_now;       // Live fault levels
    logic [10:0]        clr_mask;        // Write-one-to-clear mask
    logic [2:0]         in_ff;           // Filtered sd, pos, neg
    logic [2:0]         raw_ff;          // Last raw sample
    logic [7:0]         flt_cnt_ff;      // Filter stability count
    logic [7:0]         flt_len;         // Required stable cycles
    gdsc_pkg::gdsc_state_t state_ff;     // Operating state
    gdsc_pkg::gdsc_state_t nxt_state;
    logic [15:0]        del_cnt_ff;      // Short entry delay count
    logic               short_arm_ff;    // Entry delay done
    logic [31:0]        wdog_cnt_ff;     // Communication watchdog
    logic               wdog_exp;
    logic               grp1_any;        // Group one active
    logic               grp2_any;        // Group two active
    logic               want_on;         // Switch on demand
    logic               cmd_on_ff;       // Output stage on
    logic [7:0]         dt_cnt_ff;       // Deadtime counter
    logic               pwr_ff;          // First cycle after reset
    logic [15:0]        nxt_rdata;

    // Clear mask from register writes
    assign clr_mask = (reg_wr && reg_addr == gdsc_pkg::ADDR_STATUS)
                      ? reg_wdata[10:0] : 11'h000;

    // Live faults in status layout
    assign fault_now = {wdog_exp, 1'b0, lv_register_error,
                        neg_supply_overvolt, neg_supply_undervolt,
                        iso_register_error, sense_overcurrent,
                        thermal_shutdown, desaturation_fault,
                        high_supply_overvolt, high_supply_undervolt};

    // Group two live faults only; group one uses latched flags
    assign grp2_any = |(fault_now & gdsc_pkg::GRP2_MASK);
    assign grp1_any = |(status_ff & gdsc_pkg::GRP1_MASK)
                      || status_ff[gdsc_pkg::ST_PON];

    // ************************************************************
    // Watchdog
    // ************************************************************
    // Counts idle cycles of the data channel; no frame for WDOG_CYC
    // cycles means the low-voltage side is gone
    always_ff @(posedge clk)
    begin
        if (!rstn)
            wdog_cnt_ff <= 32'h0000_0000;
        else if (lv_frame_ok)
            wdog_cnt_ff <= 32'h0000_0000;
        else if (!wdog_exp)
            wdog_cnt_ff <= wdog_cnt_ff + 32'h0000_0001;
    end
    assign wdog_exp = (wdog_cnt_ff >= 32'(WDOG_CYC));

    // ************************************************************
    // Status flags
    // ************************************************************
    // Set wins over a clear in the same cycle; power-on flag is set
    // in the first cycle after reset release
    always_ff @(posedge clk)
    begin
        if (!rstn)
            pwr_ff <= 1'b1;
        else
            pwr_ff <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            status_ff <= gdsc_pkg::STATUS_RESET;
        else
        begin
            status_ff <= (status_ff & ~clr_mask) | fault_now;
            if (pwr_ff)
                status_ff[gdsc_pkg::ST_PON] <= 1'b1;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Soft-off each cycle starts disabled
    always_ff @(posedge clk)
    begin
        if (!rstn)
            cfg_ff <= gdsc_pkg::CFG_RESET;
        else if (reg_wr && reg_addr == gdsc_pkg::ADDR_CFG)
            // Only the defined fields are kept; spare bits read zero
            cfg_ff <= {5'h00, reg_wdata[2:0]};
    end

    // ************************************************************
    // Input filter
    // ************************************************************
    // One shared counter for all three inputs: any raw change
    // restarts it, trading per-pin independence for area
    always_comb
    begin
        case (cfg_ff[gdsc_pkg::CFG_FILT_LO +: 2])
            2'h1:    flt_len = 8'(gdsc_pkg::DEGL_A_CYC);
            2'h2:    flt_len = 8'(gdsc_pkg::DEGL_B_CYC);
            2'h3:    flt_len = 8'(gdsc_pkg::DEGL_C_CYC);
            default: flt_len = 8'(gdsc_pkg::MIN_PULSE_CYC);
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            raw_ff     <= 3'h3;
            in_ff      <= 3'h3;
            flt_cnt_ff <= 8'h00;
        end
        else
        begin
            raw_ff <= {shutdown_n, in_pos, in_neg};
            if ({shutdown_n, in_pos, in_neg} != raw_ff)
                flt_cnt_ff <= 8'h00;
            else if (flt_cnt_ff < flt_len)
                flt_cnt_ff <= flt_cnt_ff + 8'h01;
            else
                in_ff <= raw_ff;
        end
    end

    // ************************************************************
    // Operating state machine
    // ************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            gdsc_pkg::GDSC_NORMAL:
            begin
                if (wdog_exp && default_mode)
                    nxt_state = gdsc_pkg::GDSC_SHORT;
                else if (wdog_exp || grp1_any)
                    nxt_state = gdsc_pkg::GDSC_SAFE;
            end
            gdsc_pkg::GDSC_SAFE:
            begin
                // Forcing flags include power-on and comm loss
                if (!grp1_any && !status_ff[gdsc_pkg::ST_ICOM])
                    nxt_state = gdsc_pkg::GDSC_NORMAL;
            end
            gdsc_pkg::GDSC_SHORT:
            begin
                if (grp2_any)
                    nxt_state = gdsc_pkg::GDSC_SAFE;
            end
            default:
                nxt_state = gdsc_pkg::GDSC_SAFE;
        endcase
    end

    // Reset always lands in safe, default pin ignored
    always_ff @(posedge clk)
    begin
        if (!rstn)
            state_ff <= gdsc_pkg::GDSC_SAFE;
        else
            state_ff <= nxt_state;
    end

    // Entry delay; restarts on each entry, aborted by leaving
    always_ff @(posedge clk)
    begin
        if (!rstn || state_ff != gdsc_pkg::GDSC_SHORT
            || nxt_state != gdsc_pkg::GDSC_SHORT)
        begin
            del_cnt_ff   <= 16'h0000;
            short_arm_ff <= 1'b0;
        end
        else if (del_cnt_ff < 16'(gdsc_pkg::SHORT_DEL_CYC - 1))
            del_cnt_ff <= del_cnt_ff + 16'h0001;
        else
            short_arm_ff <= 1'b1;
    end

    // ************************************************************
    // Output demand and deadtime
    // ************************************************************
    // Priority: short, then override, then safe, then table
    always_comb
    begin
        if (state_ff == gdsc_pkg::GDSC_SHORT)
            want_on = short_arm_ff;
        else if (short_override)
            want_on = 1'b1;
        else if (state_ff == gdsc_pkg::GDSC_SAFE)
            want_on = 1'b0;
        else
            // Pwm channel command: sd high, pos high, neg low
            want_on = in_ff[2] && in_ff[1] && !in_ff[0];
    end

    // Any change of demand waits out the deadtime so the push-pull
    // halves never overlap
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            cmd_on_ff <= 1'b0;
            dt_cnt_ff <= 8'h00;
        end
        else if (want_on != cmd_on_ff)
        begin
            if (dt_cnt_ff < 8'(gdsc_pkg::DEAD_CYC - 1))
                dt_cnt_ff <= dt_cnt_ff + 8'h01;
            else
            begin
                cmd_on_ff <= want_on;
                dt_cnt_ff <= 8'h00;
            end
        end
        else
            dt_cnt_ff <= 8'h00;
    end

    // Pins: p goes low a cycle after n and returns high together with n
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            predrive_p        <= 1'b1;
            predrive_n        <= 1'b1;
            soft_off_pin_o    <= 1'b0;
            soft_off_pin_oe_n <= 1'b1;
        end
        else
        begin
            predrive_n <= !cmd_on_ff;
            predrive_p <= !(cmd_on_ff && !predrive_n);
            soft_off_pin_o <= 1'b0;
            // Pin driven low only when enabled and switch off
            soft_off_pin_oe_n <= cfg_ff[gdsc_pkg::CFG_SOFTDIS]
                                 || cmd_on_ff;
        end
    end

    // ************************************************************
    // Diagnostic events and read port
    // ************************************************************
    // Pulse on demand change or state change for the data channel
    always_ff @(posedge clk)
    begin
        if (!rstn)
            diag_event <= 1'b0;
        else
            diag_event <= (want_on != cmd_on_ff && dt_cnt_ff == 8'h00)
                          || (state_ff != nxt_state);
    end

    always_comb
    begin
        case (reg_addr)
            gdsc_pkg::ADDR_CFG:    nxt_rdata = {8'h00, cfg_ff};
            gdsc_pkg::ADDR_STATUS: nxt_rdata = {5'h00, status_ff};
            gdsc_pkg::ADDR_STATE:  nxt_rdata = {13'h0000, cmd_on_ff,
                                                2'(state_ff)};
            gdsc_pkg::ADDR_EVENT:  nxt_rdata = {13'h0000, in_ff};
            default:               nxt_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
            reg_rdata <= nxt_rdata;
        else
            reg_rdata <= 16'h0000;
    end
endmodule : gdsc_top

//--- test/gdsc_top_sva.sv
// Purpose: Port assertions for the gate driver state control
// Assumes: Sync active-low reset, registered outputs
// Notes:   Sees only top-level ports, bound after the module
`timescale 1ns/100ps
module gdsc_chk #(
    parameter int WDOG_CYC = gdsc_pkg::WDOG_CYC_DEF
)(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    // Pins
    input wire logic        short_override,
    input wire logic        predrive_p,
    input wire logic        predrive_n,
    input wire logic        soft_off_pin_o,
    input wire logic        soft_off_pin_oe_n,
    input wire logic        diag_event
);
    // Override hold count; 150 covers the longest filter plus deadtime
    logic [7:0] ovr_cnt_ff;
    logic [7:0] nxt_ovr_cnt;
    always_comb
    begin
        nxt_ovr_cnt = ovr_cnt_ff;
        if (!short_override)
            nxt_ovr_cnt = 8'h00;             // Released, start again
        else if (ovr_cnt_ff != 8'h96)
            nxt_ovr_cnt = ovr_cnt_ff + 8'h01; // Saturates at the check
    end
    // Counter register, cleared in reset
    always_ff @(posedge clk)
    begin
        if (!rstn)
            ovr_cnt_ff <= 8'h00;
        else
            ovr_cnt_ff <= nxt_ovr_cnt;
    end
    chk_reset_outs: assert property (@(posedge clk)
        !rstn |=> predrive_p && predrive_n && soft_off_pin_oe_n)
        else $error("outputs not off after reset");
    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr > 4'h3 |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    chk_cfg_width: assert property (@(posedge clk) disable iff (!rstn)
        reg_rd && reg_addr == gdsc_pkg::ADDR_CFG |=> reg_rdata[15:3] == 13'h0)
        else $error("config read upper bits set");
    chk_n_leads_p: assert property (@(posedge clk) disable iff (!rstn)
        !predrive_p |-> !predrive_n)
        else $error("p-side on while n-side off");
    chk_turn_on_lag: assert property (@(posedge clk) disable iff (!rstn)
        $fell(predrive_n) |=> $fell(predrive_p))
        else $error("p-side turn-on not one cycle later");
    chk_turn_off_same: assert property (@(posedge clk) disable iff (!rstn)
        $rose(predrive_n) |-> $rose(predrive_p))
        else $error("turn-off edges not together");
    chk_soft_low: assert property (@(posedge clk) disable iff (!rstn)
        soft_off_pin_o == 1'b0)
        else $error("soft-off pin drives high");
    chk_override_on: assert property (@(posedge clk) disable iff (!rstn)
        ovr_cnt_ff == 8'h96 |-> !predrive_p && !predrive_n)
        else $error("held override did not switch on");
    chk_event_lead: assert property (@(posedge clk) disable iff (!rstn)
        $changed(predrive_n) |-> $past(diag_event, 10))
        else $error("output change without earlier event pulse");
endmodule : gdsc_chk

bind gdsc_top gdsc_chk #(.WDOG_CYC(WDOG_CYC)) gdsc_chk_i (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .short_override(short_override),
    .predrive_p(predrive_p), .predrive_n(predrive_n),
    .soft_off_pin_o(soft_off_pin_o), .soft_off_pin_oe_n(soft_off_pin_oe_n),
    .diag_event(diag_event)
);

//--- test/gdsc_host_model.sv
// Purpose: Low-voltage side stand-in that sends frames to the block
// Assumes: One frame pulse every 16 cycles while talking
// Notes:   quiet models a dead low-voltage supply
`timescale 1ns/100ps
module gdsc_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control from the bench
    input wire logic quiet,
    // Frame pulse towards the block
    output logic     lv_frame_ok
);
    // Frame spacing, well inside the shortened watchdog
    logic [3:0] gap_ff;
    always_ff @(posedge clk)
    begin
        if (!rstn)
            gap_ff <= 4'h0;
        else
            gap_ff <= gap_ff + 4'h1;
    end
    // Silence stops frames so the watchdog runs out
    always_ff @(posedge clk)
    begin
        if (!rstn)
            lv_frame_ok <= 1'b0;
        else
            lv_frame_ok <= (gap_ff == 4'hf) && !quiet;
    end
endmodule : gdsc_host_model

//--- test/testbench.sv
// Purpose: Self-checking bench for the gate driver state control
// Assumes: Watchdog shortened to 50 cycles, host model sends frames
// Notes:   Driver queues expectations, a monitor pops and compares
`timescale 1ns/100ps
module testbench;
    // Stimulus towards the block
    logic        clk       = 1'b0;
    logic        rstn      = 1'b0;
    logic [3:0]  reg_addr  = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [2:0]  pins      = 3'h0;   // {shutdown_n, in_pos, in_neg}
    logic        ovr       = 1'b0;
    logic        dmode     = 1'b1;   // High at power-up on purpose
    logic        quiet     = 1'b0;
    logic [8:0]  faults    = 9'h000; // Ordered as status bits 0..8
    // Observed outputs and checking state
    logic [15:0] reg_rdata;
    logic        frame;
    logic        pp;
    logic        pn;
    logic        oe_n;
    logic [15:0] exp_q[$];
    logic        rd_d      = 1'b0;
    logic        pin_req   = 1'b0;
    logic        pin_d     = 1'b0;
    int          fail_count      = 0;
    int          samples_checked = 0;
    int          cycles          = 0;
    always #4 clk = ~clk;
    gdsc_top #(.WDOG_CYC(50)) gdsc_top_i (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .shutdown_n(pins[2]), .in_pos(pins[1]), .in_neg(pins[0]),
        .short_override(ovr), .default_mode(dmode), .lv_frame_ok(frame),
        .high_supply_undervolt(faults[0]), .high_supply_overvolt(faults[1]),
        .desaturation_fault(faults[2]), .thermal_shutdown(faults[3]),
        .sense_overcurrent(faults[4]), .iso_register_error(faults[5]),
        .neg_supply_undervolt(faults[6]), .neg_supply_overvolt(faults[7]),
        .lv_register_error(faults[8]), .predrive_p(pp), .predrive_n(pn),
        .soft_off_pin_o(), .soft_off_pin_oe_n(oe_n), .diag_event()
    );
    gdsc_host_model gdsc_host_model_i (
        .clk(clk), .rstn(rstn), .quiet(quiet), .lv_frame_ok(frame)
    );
    // State register image: output-on bit over the state code
    function automatic logic [15:0] st(input logic on,
                                       input gdsc_pkg::gdsc_state_t s);
        return {13'h0, on, s};
    endfunction : st
    task automatic test_done;
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc
    // One-cycle strobes, then an idle edge so strobes never collide
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        wait_cyc(1);
        reg_wr    <= 1'b0;
        wait_cyc(1);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        wait_cyc(1);
        reg_rd   <= 1'b0;
        wait_cyc(1);
    endtask : rd
    // Queue a pin check: switch on means both pre-drivers low
    task automatic pin_exp(input logic on, input logic oe);
        exp_q.push_back({13'h0, ~on, ~on, oe});
        pin_req <= 1'b1;
        wait_cyc(1);
        pin_req <= 1'b0;
        wait_cyc(1);
    endtask : pin_exp
    // Monitor: read data stands one cycle after the strobe
    always @(posedge clk)
    begin
        rd_d  <= reg_rd;
        pin_d <= pin_req;
        if (rd_d)
            chk(reg_rdata, exp_q.pop_front());
        if (pin_d)
            chk({13'h0, pp, pn, oe_n}, exp_q.pop_front());
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    initial
    begin
        int v;
        v = $urandom(32'h5ab150a7);
        wait_cyc(2);
        rstn <= 1'b1;
        wait_cyc(2);
        pin_exp(1'b0, 1'b1);
        rd(gdsc_pkg::ADDR_CFG, 16'h0004);
        rd(gdsc_pkg::ADDR_STATUS, 16'h0200);
        rd(gdsc_pkg::ADDR_STATE, st(1'b0, gdsc_pkg::GDSC_SAFE));
        wr(4'(4 + $urandom % 12), 16'hffff);
        rd(4'(4 + $urandom % 12), 16'h0000);
        rd(gdsc_pkg::ADDR_CFG, 16'h0004);
        wr(gdsc_pkg::ADDR_STATUS, 16'h07ff);
        rd(gdsc_pkg::ADDR_STATE, st(1'b0, gdsc_pkg::GDSC_NORMAL));
        // Full truth table, soft-off each cycle enabled then disabled
        for (int c = 0; c < 2; c++)
        begin
            wr(gdsc_pkg::ADDR_CFG, c ? 16'h0004 : 16'h0000);
            for (int k = 0; k < 8; k++)
            begin
                pins <= 3'(k);
                wait_cyc(40);
                pin_exp(k == 6, k == 6 || c == 1);
            end
        end
        // Short pulses on an on-demand must not reach the outputs
        for (int f = 0; f < 6; f++)
        begin
            wr(gdsc_pkg::ADDR_CFG, 16'(f / 3));
            pins <= 3'b110 ^ 3'(1 << ($urandom % 3));
            wait_cyc(1 + $urandom % ((f < 3) ? 4 : 17));
            pins <= 3'b110;
            wait_cyc(30);
            pin_exp(1'b1, 1'b1);
        end
        wr(gdsc_pkg::ADDR_CFG, 16'hfffc);
        rd(gdsc_pkg::ADDR_CFG, 16'h0004);
        faults <= 9'(1 << ($urandom % 9));
        wait_cyc(40);
        pin_exp(1'b0, 1'b1);
        ovr <= 1'b1;
        wait_cyc(160);
        pin_exp(1'b1, 1'b1);
        ovr <= 1'b0;
        faults <= 9'h000;
        pins <= 3'b010;
        wait_cyc(40);
        wr(gdsc_pkg::ADDR_STATUS, 16'h07ff);
        // Comm loss: short with delay, abort mid-delay, then to safe
        for (int r = 0; r < 3; r++)
        begin
            dmode <= 1'(r < 2);
            quiet <= 1'b1;
            wait_cyc(80);
            rd(gdsc_pkg::ADDR_STATE, st(1'b0, (r < 2) ? gdsc_pkg::GDSC_SHORT
                                                : gdsc_pkg::GDSC_SAFE));
            if (r == 0)
            begin
                wait_cyc(300);
                pin_exp(1'b1, 1'b1);
            end
            faults <= 9'(1 << ($urandom % 6));
            wait_cyc(40);
            rd(gdsc_pkg::ADDR_STATE, st(1'b0, gdsc_pkg::GDSC_SAFE));
            wait_cyc(300);
            pin_exp(1'b0, 1'b1);
            faults <= 9'h000;
            quiet <= 1'b0;
            wait_cyc(40);
            wr(gdsc_pkg::ADDR_STATUS, 16'h07ff);
        end
        test_done();
    end
endmodule : testbench
